// ### bench/esr_host.sv
`timescale 1ns/10ps
module esr_host (
  input wire logic i_clk,
  output logic o_shift_clock,
  output logic o_load_select,
  output logic o_serial_in,
  output logic [7:0] o_parallel_in
);
  initial begin
    o_shift_clock = 1'b0;
    o_load_select = 1'b0;
    o_serial_in = 1'b0;
    o_parallel_in = 8'h00;
  end

  // setup 3 cycles, clock high 3, then inputs scrambled once hold is over
  task automatic apply_edge(input logic ls, input logic si, input logic [7:0] pi);
    @(posedge i_clk);
    o_load_select <= ls;
    o_serial_in <= si;
    o_parallel_in <= pi;
    repeat (3) @(posedge i_clk);
    o_shift_clock <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_shift_clock <= 1'b0;
    o_load_select <= ~ls;
    o_serial_in <= ~si;
    o_parallel_in <= ~pi;
    repeat (6) @(posedge i_clk);
  endtask : apply_edge
endmodule : esr_host

// ### bench/test_eight_stage_load_shift_register.sv
`timescale 1ns/10ps
module test_eight_stage_load_shift_register;
  import esr_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic drain_hold = 1'b0;
  logic shift_clock, load_select, serial_in;
  logic [7:0] parallel_in;
  logic [ESR_TAPS-1:0] taps;
  logic overrun;
  logic [7:0] model_ff = 8'h00;
  int err_count = 0;
  int check_count = 0;

  always #5 i_clk = ~i_clk;

  esr_host i_host (.i_clk(i_clk), .o_shift_clock(shift_clock),
    .o_load_select(load_select), .o_serial_in(serial_in), .o_parallel_in(parallel_in));

  esr_shift_register i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_shift_clock(shift_clock), .i_load_select(load_select), .i_serial_in(serial_in),
    .i_parallel_in(parallel_in), .i_drain_hold(drain_hold), .o_tap_outputs(taps),
    .o_overrun(overrun));

  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one host edge; model follows only when the edge is accepted
  task automatic do_edge(input logic ls, input logic si, input logic [7:0] pi, input bit keep);
    i_host.apply_edge(ls, si, pi);
    if (keep) begin
      model_ff = ls ? pi : {model_ff[6:0], si};
    end
  endtask : do_edge

  task automatic test_load();
    do_edge(1'b1, 1'b0, 8'hA5, 1'b1);
    chk("taps load a5", 3'h5, taps);
    do_edge(1'b1, 1'b1, 8'h4A, 1'b1);
    chk("taps load 4a", 3'h2, taps);
  endtask : test_load

  task automatic test_shift();
    logic [7:0] pat;
    pat = 8'h2D;
    for (int i = 0; i < 8; i++) begin
      do_edge(1'b0, pat[i], 8'hFF, 1'b1);
      chk("taps shift", model_ff[7:5], taps);
    end
    chk("first bit at tap 7", {2'b00, pat[0]}, {2'b00, taps[2]});
  endtask : test_shift

  task automatic test_overrun();
    logic [7:0] held;
    held = model_ff;
    chk("overrun idle", 3'h0, {2'b00, overrun});
    drain_hold <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      do_edge(1'b0, ~held[i], 8'h00, i < 4);
    end
    chk("taps held", held[7:5], taps);
    chk("overrun set", 3'h1, {2'b00, overrun});
    drain_hold <= 1'b0;
    repeat (12) @(posedge i_clk);
    chk("taps drained", model_ff[7:5], taps);
  endtask : test_overrun

  task automatic give_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #20000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("taps after reset", 3'h0, taps);
    test_load();
    test_shift();
    test_overrun();
    give_verdict();
  end
endmodule : test_eight_stage_load_shift_register

// ### hdl/esr_shift_register.sv
// Behaviour
// - eight flip-flop stages in one chain, holding their value between edges.
// - state changes only when a queued shift clock rising edge is popped; inputs sampled at that edge.
// - load select high loads all parallel inputs; taps show inputs five to seven.
// - load select low shifts right, serial input entering stage zero.
// - serial bit reaches taps five, six, seven after six, seven, eight shifts.
// - only stages five, six and seven drive outputs.
// - each stage takes its input value once per edge, no ripple.
`timescale 1ns/10ps

module esr_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic do_push;
  logic do_pop;

  assign o_in_ready = (count_ff != FULL_CNT);
  assign o_out_valid = (count_ff != '0);
  assign o_out_data = mem_ff[rd_ptr_ff];
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = o_out_valid && i_out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (do_pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      count_ff <= '0;
    end else if (do_push && !do_pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (do_pop && !do_push) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    count_ff <= FULL_CNT)
    else $error("fifo count above depth");

  // queue bookkeeping
  fifo_push_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    do_push && !do_pop |=> count_ff == $past(count_ff) + 1'b1)
    else $error("fifo count missed a push");

  fifo_pop_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    do_pop && !do_push |=> count_ff == $past(count_ff) - 1'b1)
    else $error("fifo count missed a pop");

  // first word into an empty queue is the one offered next
  fifo_first_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    do_push && count_ff == '0 |=> o_out_data == $past(i_in_data))
    else $error("fifo head word wrong");

  fifo_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
    else $error("fifo head changed while stalled");

  fifo_ptr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    count_ff == '0 || count_ff == FULL_CNT |-> wr_ptr_ff == rd_ptr_ff)
    else $error("fifo pointers apart when empty or full");

  fifo_refuse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_in_valid && !o_in_ready && !i_out_ready |=> count_ff == FULL_CNT)
    else $error("refused word changed a full queue");

  fifo_wr_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_in_ready |=> $stable(wr_ptr_ff))
    else $error("write pointer moved while full");
endmodule : esr_fifo

module esr_shift_register
  import esr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_shift_clock,
  input wire logic i_load_select,
  input wire logic i_serial_in,
  input wire logic [ESR_STAGES-1:0] i_parallel_in,
  input wire logic i_drain_hold,
  output logic [ESR_TAPS-1:0] o_tap_outputs,
  output logic o_overrun
);
  logic [2:0] clk_sync_ff;
  esr_sample_t smp_s1_ff;
  esr_sample_t smp_s2_ff;
  logic clk_rise;
  logic fifo_in_ready;
  logic fifo_out_valid;
  esr_sample_t fifo_out;
  logic pop;
  logic [ESR_STAGES-1:0] stage_ff;
  logic [ESR_STAGES-1:0] nxt_stage;
  logic [ESR_TAPS-1:0] tap_ff;
  logic overrun_ff;

  // two-flop synchronisers; third clock flop only feeds edge detection
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      clk_sync_ff <= '0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[1:0], i_shift_clock};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      smp_s1_ff <= ESR_SAMPLE_RST;
      smp_s2_ff <= ESR_SAMPLE_RST;
    end else begin
      smp_s1_ff <= '{load_select: i_load_select, serial_in: i_serial_in,
                     parallel_in: i_parallel_in};
      smp_s2_ff <= smp_s1_ff;
    end
  end

  // falling edges produce nothing
  assign clk_rise = clk_sync_ff[1] && !clk_sync_ff[2];

  rise_once_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clk_rise |=> !clk_rise)
    else $error("one shift clock edge pushed twice");

  // an edge into an empty queue carries the sample taken alongside it
  edge_queue_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clk_rise && !fifo_out_valid |=> fifo_out_valid && fifo_out == $past(smp_s2_ff))
    else $error("edge sample not queued");

  edge_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !clk_rise && !fifo_out_valid |=> !fifo_out_valid)
    else $error("queue filled without a shift clock edge");

  esr_fifo #(
    .WIDTH(ESR_SAMPLE_W),
    .DEPTH(ESR_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(clk_rise),
    .o_in_ready(fifo_in_ready),
    .i_in_data(smp_s2_ff),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(!i_drain_hold),
    .o_out_data(fifo_out)
  );

  assign pop = fifo_out_valid && !i_drain_hold;

  drain_stall_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_drain_hold |-> !pop)
    else $error("edge applied while drain held");

  // edge lost when the queue is full
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      overrun_ff <= 1'b0;
    end else if (clk_rise && !fifo_in_ready) begin
      overrun_ff <= 1'b1;
    end
  end

  // overrun flag
  overrun_set_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clk_rise && !fifo_in_ready |=> o_overrun)
    else $error("dropped edge not flagged");

  overrun_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_overrun |=> o_overrun)
    else $error("overrun flag cleared without reset");

  overrun_cause_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_overrun) |-> $past(clk_rise) && !$past(fifo_in_ready))
    else $error("overrun flagged without a dropped edge");

  always_comb begin
    nxt_stage = stage_ff;
    if (pop) begin
      if (fifo_out.load_select) begin
        nxt_stage = fifo_out.parallel_in;
      end else begin
        nxt_stage = {stage_ff[ESR_STAGES-2:0], fifo_out.serial_in};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stage_ff <= ESR_STAGE_RST;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tap_ff <= ESR_TAP_RST;
    end else begin
      tap_ff <= nxt_stage[ESR_TAP_HI:ESR_TAP_LO];
    end
  end

  assign o_tap_outputs = tap_ff;
  assign o_overrun = overrun_ff;

  // helper: serial bits of consecutive shifts since last load
  logic [ESR_STAGES-1:0] hist_ff;
  logic [3:0] run_ff;
  // shift counts after which tap five, tap six and every stage follow the history
  localparam logic [3:0] RUN_TAP5 = 4'(ESR_TAP_LO + 1);
  localparam logic [3:0] RUN_TAP6 = 4'(ESR_TAP_HI);
  localparam logic [3:0] RUN_FULL = 4'(ESR_STAGES);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hist_ff <= '0;
      run_ff <= '0;
    end else if (pop && fifo_out.load_select) begin
      run_ff <= '0;
    end else if (pop) begin
      hist_ff <= {hist_ff[ESR_STAGES-2:0], fifo_out.serial_in};
      run_ff <= (run_ff == RUN_FULL) ? run_ff : run_ff + 4'h1;
    end
  end

  hold_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !pop |=> $stable(stage_ff) && $stable(o_tap_outputs))
    else $error("stages changed without a shift edge");

  rise_push_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(clk_sync_ff[2]) |-> !clk_rise ##0 $past(clk_rise))
    else $error("edge detect mismatched");

  load_taps_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop && fifo_out.load_select |=>
      stage_ff == $past(fifo_out.parallel_in) &&
      o_tap_outputs == $past(fifo_out.parallel_in[ESR_TAP_HI:ESR_TAP_LO]))
    else $error("parallel load wrong");

  shift_in_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop && !fifo_out.load_select |=> stage_ff[0] == $past(fifo_out.serial_in))
    else $error("serial input not in stage zero");

  serial_five_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    run_ff >= RUN_TAP5 |-> o_tap_outputs[0] == hist_ff[5])
    else $error("serial bit late on tap five");

  serial_seven_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    run_ff == RUN_FULL |-> o_tap_outputs[2] == hist_ff[7] && o_tap_outputs[1] == hist_ff[6])
    else $error("serial bit late on tap six or seven");

  taps_match_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_tap_outputs == stage_ff[ESR_TAP_HI:ESR_TAP_LO])
    else $error("taps differ from final stages");

  no_ripple_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop && !fifo_out.load_select |=>
      stage_ff[ESR_STAGES-1:1] == $past(stage_ff[ESR_STAGES-2:0]))
    else $error("shift moved more than one stage");

  shift_chain_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop && !fifo_out.load_select |=>
      stage_ff == {$past(stage_ff[ESR_STAGES-2:0]), $past(fifo_out.serial_in)})
    else $error("shift chain contents wrong");

  serial_six_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    run_ff >= RUN_TAP6 |-> o_tap_outputs[1] == hist_ff[6])
    else $error("serial bit late on tap six");

  stage_history_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    run_ff == RUN_FULL |-> stage_ff == hist_ff)
    else $error("stages differ from serial history");
endmodule : esr_shift_register

// ### shared/esr_pkg.sv
package esr_pkg;
  localparam int unsigned ESR_STAGES = 8;
  localparam int unsigned ESR_TAP_LO = 5;
  localparam int unsigned ESR_TAP_HI = 7;
  localparam int unsigned ESR_TAPS = ESR_TAP_HI - ESR_TAP_LO + 1;
  localparam int unsigned ESR_FIFO_DEPTH = 4;
  localparam logic [ESR_STAGES-1:0] ESR_STAGE_RST = 8'h00;
  localparam logic [ESR_TAPS-1:0] ESR_TAP_RST = 3'h0;

  typedef struct packed {
    logic load_select;
    logic serial_in;
    logic [ESR_STAGES-1:0] parallel_in;
  } esr_sample_t;

  localparam int unsigned ESR_SAMPLE_W = $bits(esr_sample_t);
  localparam esr_sample_t ESR_SAMPLE_RST = '0;
endpackage : esr_pkg
